// ---- comparator_ctrl.sv ----
// Purpose: control logic around one analog comparator, reached over APB
// Assumes: all inputs synchronous to pclk; analog result arrives on raw_result
// Notes:   first-comparator triggers are enabled by parameter IS_FIRST
`timescale 1ns/1ps

// ==========================================
// shared constants
package comparator_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL0_OFFSET    = 12'h000;
  localparam logic [11:0] MODE_OFFSET     = 12'h004;
  localparam logic [11:0] CTRL1_OFFSET    = 12'h008;
  localparam logic [11:0] MUXSEL_OFFSET   = 12'h00C;
  // control0 field positions
  localparam int ENABLE_BIT        = 7;
  localparam int OUT_FLAG_BIT      = 6;
  localparam int RISE_FLAG_BIT     = 5;
  localparam int FALL_FLAG_BIT     = 4;
  localparam int HYP_LSB           = 2;
  localparam int HYN_LSB           = 0;
  // mode field positions
  localparam int INVERT_BIT        = 6;
  localparam int RISE_IE_BIT       = 5;
  localparam int FALL_IE_BIT       = 4;
  localparam int IN_SEL_LSB        = 2;
  // control1 and mux select field positions
  localparam int HOLD_EN_BIT       = 0;
  localparam int NEG_CODE_LSB      = 4;
  localparam int POS_CODE_LSB      = 0;
  // input select arrangements
  localparam logic [1:0] ARR_DIRECT   = 2'h0;
  localparam logic [1:0] ARR_NEG_GND  = 2'h1;
  localparam logic [1:0] ARR_NEG_DAC  = 2'h2;
  localparam logic [1:0] ARR_POS_DAC  = 2'h3;
  // negative channel codes; 13 and 14 connect nothing
  localparam logic [3:0] NEG_PORT1_LAST = 4'h7;
  localparam logic [3:0] NEG_GND_CODE   = 4'h8;
  localparam logic [3:0] NEG_PORT2_BASE = 4'h9;
  localparam logic [3:0] NEG_PORT2_LAST = 4'hC;
  localparam logic [3:0] NEG_VDD_CODE   = 4'hF;
  // negative multiplexer pins per port
  localparam int NEG_PORT1_PINS    = 8;
  localparam int NEG_PORT2_PINS    = 4;
  // hysteresis encodings
  localparam logic [1:0] HYST_OFF      = 2'h0;
  localparam logic [1:0] HYST_MAX      = 2'h3;
  // reset values
  localparam logic [1:0] HYST_RESET    = 2'h0;
  localparam logic [1:0] ARR_RESET     = 2'h0;
  localparam logic [3:0] MUX_RESET     = 4'h0;
endpackage : comparator_pkg

module comparator_ctrl #(
  parameter bit IS_FIRST = 1'b1
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // analog core
  input  wire logic        raw_result,
  input  wire logic        capture_out,
  output logic             comp_power_on,
  output logic [1:0]       hyst_pos_level,
  output logic [1:0]       hyst_neg_level,
  output logic             hyst_pos_max,
  output logic             hyst_neg_max,
  // negative and positive multiplexers
  output logic [7:0]       neg_port1_sel,
  output logic [3:0]       neg_port2_sel,
  output logic             neg_gnd_sel,
  output logic             neg_vdd_sel,
  output logic [3:0]       pos_channel_sel,
  // input arrangement
  output logic             neg_in_from_mux,
  output logic             neg_in_from_gnd,
  output logic             neg_in_from_dac,
  output logic             pos_in_from_mux,
  output logic             pos_in_from_dac,
  output logic             dac_ref_from_neg,
  output logic             dac_ref_from_pos,
  output logic             dac_enable,
  // results
  output logic             pin_sync_out,
  output logic             pin_async_out,
  output logic             comp_irq,
  output logic             reset_source,
  output logic             kill_trigger
);

  typedef struct packed {
    logic        enable;
    logic        rise_flag;
    logic        fall_flag;
    logic [1:0]  hyp;
    logic [1:0]  hyn;
    logic        invert;
    logic        rise_ie;
    logic        fall_ie;
    logic [1:0]  arrange;
    logic        hold_en;
    logic [3:0]  neg_code;
    logic [3:0]  pos_code;
    logic [31:0] rdata;
    logic        err;
  } ctrl_t;

  ctrl_t ctrl_reg;
  ctrl_t ctrl_next;

  logic sync_val;
  logic async_val;
  logic rise_pulse;
  logic fall_pulse;
  logic setup;
  logic wr_access;
  logic hit_ctrl0;
  logic hit_mode;
  logic hit_ctrl1;
  logic hit_mux;
  logic mapped;

  // ==========================================
  // output conditioning
  cmp_output_stage u_stage (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (ctrl_reg.enable),
    .invert      (ctrl_reg.invert),
    .hold_en     (ctrl_reg.hold_en),
    .capture_out (capture_out),
    .raw_result  (raw_result),
    .async_out   (async_val),
    .sync_out    (sync_val),
    .rise_pulse  (rise_pulse),
    .fall_pulse  (fall_pulse)
  );

  // ==========================================
  // address decode
  // only the four word offsets decode; anything else answers with an error
  assign hit_ctrl0 = (paddr == comparator_pkg::CTRL0_OFFSET);
  assign hit_mode  = (paddr == comparator_pkg::MODE_OFFSET);
  assign hit_ctrl1 = (paddr == comparator_pkg::CTRL1_OFFSET);
  assign hit_mux   = (paddr == comparator_pkg::MUXSEL_OFFSET);
  assign mapped    = hit_ctrl0 | hit_mode | hit_ctrl1 | hit_mux;
  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite & mapped;

  // ==========================================
  // register next state
  always_comb begin
    ctrl_next = ctrl_reg;
    // software writes take effect in the access phase
    // a 1 written to a flag bit sets it, as for any read-write bit
    if (wr_access && hit_ctrl0) begin
      ctrl_next.enable    = pwdata[comparator_pkg::ENABLE_BIT];
      ctrl_next.rise_flag = pwdata[comparator_pkg::RISE_FLAG_BIT];
      ctrl_next.fall_flag = pwdata[comparator_pkg::FALL_FLAG_BIT];
      ctrl_next.hyp = pwdata[comparator_pkg::HYP_LSB +: 2];
      ctrl_next.hyn = pwdata[comparator_pkg::HYN_LSB +: 2];
    end
    if (wr_access && hit_mode) begin
      ctrl_next.invert  = pwdata[comparator_pkg::INVERT_BIT];
      ctrl_next.rise_ie = pwdata[comparator_pkg::RISE_IE_BIT];
      ctrl_next.fall_ie = pwdata[comparator_pkg::FALL_IE_BIT];
      ctrl_next.arrange = pwdata[comparator_pkg::IN_SEL_LSB +: 2];
    end
    if (wr_access && hit_ctrl1) begin
      ctrl_next.hold_en = pwdata[comparator_pkg::HOLD_EN_BIT];
    end
    if (wr_access && hit_mux) begin
      ctrl_next.neg_code = pwdata[comparator_pkg::NEG_CODE_LSB +: 4];
      ctrl_next.pos_code = pwdata[comparator_pkg::POS_CODE_LSB +: 4];
    end
    // hardware set wins over a same-cycle software clear
    if (rise_pulse) begin
      ctrl_next.rise_flag = 1'b1;
    end
    if (fall_pulse) begin
      ctrl_next.fall_flag = 1'b1;
    end
    // read data is captured in the setup cycle
    // latching in setup keeps prdata steady for the whole access phase
    // reserved positions read back as zero
    ctrl_next.err = 1'b0;
    if (setup) begin
      ctrl_next.rdata = 32'h0000_0000;
      ctrl_next.err   = ~mapped;
      if (!pwrite && hit_ctrl0) begin
        ctrl_next.rdata[comparator_pkg::ENABLE_BIT]    = ctrl_reg.enable;
        ctrl_next.rdata[comparator_pkg::OUT_FLAG_BIT]  = sync_val;
        ctrl_next.rdata[comparator_pkg::RISE_FLAG_BIT] = ctrl_reg.rise_flag;
        ctrl_next.rdata[comparator_pkg::FALL_FLAG_BIT] = ctrl_reg.fall_flag;
        ctrl_next.rdata[comparator_pkg::HYP_LSB +: 2]  = ctrl_reg.hyp;
        ctrl_next.rdata[comparator_pkg::HYN_LSB +: 2]  = ctrl_reg.hyn;
      end
      if (!pwrite && hit_mode) begin
        ctrl_next.rdata[comparator_pkg::INVERT_BIT]    = ctrl_reg.invert;
        ctrl_next.rdata[comparator_pkg::RISE_IE_BIT]   = ctrl_reg.rise_ie;
        ctrl_next.rdata[comparator_pkg::FALL_IE_BIT]   = ctrl_reg.fall_ie;
        ctrl_next.rdata[comparator_pkg::IN_SEL_LSB +: 2] = ctrl_reg.arrange;
      end
      if (!pwrite && hit_ctrl1) begin
        ctrl_next.rdata[comparator_pkg::HOLD_EN_BIT]   = ctrl_reg.hold_en;
      end
      if (!pwrite && hit_mux) begin
        ctrl_next.rdata[comparator_pkg::NEG_CODE_LSB +: 4] = ctrl_reg.neg_code;
        ctrl_next.rdata[comparator_pkg::POS_CODE_LSB +: 4] = ctrl_reg.pos_code;
      end
    end
  end

  // ==========================================
  // state register
  // reset leaves the comparator off, inputs direct, channel zero on both muxes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg          <= '0;
      ctrl_reg.hyp      <= comparator_pkg::HYST_RESET;
      ctrl_reg.hyn      <= comparator_pkg::HYST_RESET;
      ctrl_reg.arrange  <= comparator_pkg::ARR_RESET;
      ctrl_reg.neg_code <= comparator_pkg::MUX_RESET;
      ctrl_reg.pos_code <= comparator_pkg::MUX_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================
  // apb answer, zero wait states
  // every register answers in the first access cycle
  assign pready  = 1'b1;
  assign prdata  = ctrl_reg.rdata;
  assign pslverr = ctrl_reg.err & psel & penable;

  // ==========================================
  // supply and hysteresis
  assign comp_power_on  = ctrl_reg.enable;
  assign hyst_pos_level = ctrl_reg.hyp;
  assign hyst_neg_level = ctrl_reg.hyn;
  assign hyst_pos_max   = (ctrl_reg.hyp == comparator_pkg::HYST_MAX);
  assign hyst_neg_max   = (ctrl_reg.hyn == comparator_pkg::HYST_MAX);

  // ==========================================
  // negative multiplexer decode; codes 13 and 14 select nothing
  genvar gi;
  generate
    for (gi = 0; gi < comparator_pkg::NEG_PORT1_PINS; gi++) begin : g_port1
      assign neg_port1_sel[gi] = (ctrl_reg.neg_code == 4'(gi));
    end
    for (gi = 0; gi < comparator_pkg::NEG_PORT2_PINS; gi++) begin : g_port2
      assign neg_port2_sel[gi] =
        (ctrl_reg.neg_code == 4'(comparator_pkg::NEG_PORT2_BASE + 4'(gi)));
    end
  endgenerate

  assign neg_gnd_sel     = (ctrl_reg.neg_code == comparator_pkg::NEG_GND_CODE);
  assign neg_vdd_sel     = (ctrl_reg.neg_code == comparator_pkg::NEG_VDD_CODE);
  assign pos_channel_sel = ctrl_reg.pos_code;

  // ==========================================
  // input arrangement
  always_comb begin
    neg_in_from_mux  = 1'b0;
    neg_in_from_gnd  = 1'b0;
    neg_in_from_dac  = 1'b0;
    pos_in_from_mux  = 1'b0;
    pos_in_from_dac  = 1'b0;
    dac_ref_from_neg = 1'b0;
    dac_ref_from_pos = 1'b0;
    case (ctrl_reg.arrange)
      comparator_pkg::ARR_DIRECT: begin
        pos_in_from_mux = 1'b1;
        neg_in_from_mux = 1'b1;
      end
      comparator_pkg::ARR_NEG_GND: begin
        pos_in_from_mux = 1'b1;
        neg_in_from_gnd = 1'b1;
      end
      comparator_pkg::ARR_NEG_DAC: begin
        pos_in_from_mux  = 1'b1;
        dac_ref_from_neg = 1'b1;
        neg_in_from_dac  = 1'b1;
      end
      comparator_pkg::ARR_POS_DAC: begin
        neg_in_from_mux  = 1'b1;
        dac_ref_from_pos = 1'b1;
        pos_in_from_dac  = 1'b1;
      end
      // unreachable with a 2-bit field; falls back to direct inputs
      default: begin
        pos_in_from_mux = 1'b1;
        neg_in_from_mux = 1'b1;
      end
    endcase
  end

  assign dac_enable = dac_ref_from_neg | dac_ref_from_pos;

  // ==========================================
  // result consumers
  // disabling forces the synced output low, which can itself raise the fall flag
  assign pin_sync_out  = sync_val;
  assign pin_async_out = async_val;
  // level request: stays up until the flag or its enable is cleared
  assign comp_irq = (ctrl_reg.rise_flag & ctrl_reg.rise_ie)
                  | (ctrl_reg.fall_flag & ctrl_reg.fall_ie);
  // only the first comparator feeds the reset and channel kill logic
  assign reset_source = IS_FIRST & sync_val;
  assign kill_trigger = IS_FIRST & sync_val;

endmodule : comparator_ctrl

// ---- cmp_output_stage.sv ----
// Purpose: comparator output conditioning stage (invert, hold, sync, edges)
// Assumes: raw comparator result is already a clean level synchronous to pclk
// Notes:   the unsynchronised output is combinational by intent
`timescale 1ns/1ps

// ==========================================
// output stage
module cmp_output_stage (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // controls
  input  wire logic enable,
  input  wire logic invert,
  input  wire logic hold_en,
  input  wire logic capture_out,
  // analog result, 1 when positive input is higher
  input  wire logic raw_result,
  // conditioned results
  output logic      async_out,
  output logic      sync_out,
  output logic      rise_pulse,
  output logic      fall_pulse
);

  typedef struct packed {
    logic held;
    logic sync;
    logic prev;
  } stage_t;

  stage_t st_reg;
  stage_t st_next;
  logic   inv_val;
  logic   cond_val;

  // ==========================================
  // conditioning
  always_comb begin
    inv_val  = raw_result ^ invert;
    cond_val = (hold_en && !capture_out) ? st_reg.held : inv_val;
    st_next      = st_reg;
    st_next.held = cond_val;
    st_next.sync = enable & cond_val;
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign async_out  = enable & cond_val;
  assign sync_out   = st_reg.sync;
  assign rise_pulse = st_reg.sync & ~st_reg.prev;
  assign fall_pulse = ~st_reg.sync & st_reg.prev;

endmodule : cmp_output_stage

// ---- comparator_input_output_control_props.sv ----
// Purpose: port-level checks of comparator_ctrl
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes:   bound into every comparator_ctrl instance
`timescale 1ns/1ps

// ==========================================
// checker
module cmp_ctrl_props #(
  parameter bit IS_FIRST = 1'b1
) (
  // clock, reset and bus
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pslverr,
  // analog controls
  input wire logic       comp_power_on,
  input wire logic [1:0] hyst_pos_level,
  input wire logic       hyst_pos_max,
  input wire logic [7:0] neg_port1_sel,
  input wire logic [3:0] neg_port2_sel,
  input wire logic       neg_gnd_sel,
  input wire logic       neg_vdd_sel,
  input wire logic       neg_in_from_mux,
  input wire logic       neg_in_from_gnd,
  input wire logic       neg_in_from_dac,
  input wire logic       pos_in_from_mux,
  input wire logic       pos_in_from_dac,
  input wire logic       dac_ref_from_neg,
  input wire logic       dac_ref_from_pos,
  input wire logic       dac_enable,
  // results
  input wire logic       pin_sync_out,
  input wire logic       pin_async_out,
  input wire logic       comp_irq,
  input wire logic       reset_source,
  input wire logic       kill_trigger
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_neg_onehot: assert property ($onehot0({neg_port1_sel, neg_port2_sel, neg_gnd_sel, neg_vdd_sel}))
    else $error("negative select not one-hot");
  a_arrange_exclusive: assert property ($onehot({neg_in_from_mux, neg_in_from_gnd, neg_in_from_dac})
    && $onehot({pos_in_from_mux, pos_in_from_dac})) else $error("input arrangement not exclusive");
  a_dac_usage: assert property (dac_enable == (neg_in_from_dac || pos_in_from_dac))
    else $error("dac enable wrong");
  a_dac_reference: assert property (dac_ref_from_neg == neg_in_from_dac && dac_ref_from_pos == pos_in_from_dac)
    else $error("dac reference wrong");
  a_sync_follows: assert property (comp_power_on && $past(comp_power_on) |-> pin_sync_out == $past(pin_async_out))
    else $error("synchronised output not one cycle behind");
  a_off_low: assert property (!comp_power_on |-> !pin_async_out && (!pin_sync_out || $past(comp_power_on)))
    else $error("output high while disabled");
  a_irq_cause: assert property ($rose(comp_irq) |-> $past(pin_sync_out) != $past(pin_sync_out, 2)
    || $past(psel && penable && pwrite)) else $error("interrupt without edge or write");
  a_trigger_copy: assert property (reset_source == (IS_FIRST && pin_sync_out)
    && kill_trigger == (IS_FIRST && pin_sync_out)) else $error("trigger outputs wrong");
  a_hyst_max: assert property (hyst_pos_max == (hyst_pos_level == 2'h3))
    else $error("hysteresis max flag wrong");
  a_err_phase: assert property (pslverr |-> psel && penable) else $error("error outside access phase");

  c_irq:  cover property ($rose(comp_irq));
  c_fall: cover property ($fell(pin_sync_out));
  c_dac:  cover property (dac_enable);
  c_err:  cover property (pslverr);
endmodule : cmp_ctrl_props

bind comparator_ctrl cmp_ctrl_props #(.IS_FIRST(IS_FIRST)) u_cmp_ctrl_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr),
  .comp_power_on(comp_power_on), .hyst_pos_level(hyst_pos_level), .hyst_pos_max(hyst_pos_max),
  .neg_port1_sel(neg_port1_sel), .neg_port2_sel(neg_port2_sel), .neg_gnd_sel(neg_gnd_sel),
  .neg_vdd_sel(neg_vdd_sel), .neg_in_from_mux(neg_in_from_mux), .neg_in_from_gnd(neg_in_from_gnd),
  .neg_in_from_dac(neg_in_from_dac), .pos_in_from_mux(pos_in_from_mux), .pos_in_from_dac(pos_in_from_dac),
  .dac_ref_from_neg(dac_ref_from_neg), .dac_ref_from_pos(dac_ref_from_pos), .dac_enable(dac_enable),
  .pin_sync_out(pin_sync_out), .pin_async_out(pin_async_out), .comp_irq(comp_irq),
  .reset_source(reset_source), .kill_trigger(kill_trigger));

// ---- analog_front.sv ----
// Purpose: behavioural analog side: input voltages and capture channel
// Assumes: levels in arbitrary millivolt steps
// Notes:   result is 1 only when positive strictly exceeds negative
`timescale 1ns/1ps

// ==========================================
// analog front
module analog_front (
  // levels from the bench
  input  wire logic [7:0] pos_mv,
  input  wire logic [7:0] neg_mv,
  input  wire logic       cap_level,
  // to the comparator block
  output logic            raw_result,
  output logic            capture_out
);
  assign raw_result  = pos_mv > neg_mv;
  assign capture_out = cap_level;
endmodule : analog_front

// ---- comparator_input_output_control_tb.sv ----
// Purpose: self-checking bench of comparator_ctrl over APB
// Assumes: zero-wait APB slave, flags visible two edges after a result change
// Notes:   negative input held at mid level, positive swept
`timescale 1ns/1ps

// ==========================================
// testbench
module comparator_input_output_control_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, raw_result, capture_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        comp_power_on, hyst_pos_max, hyst_neg_max, neg_gnd_sel, neg_vdd_sel, dac_enable;
  logic [1:0]  hyst_pos_level, hyst_neg_level;
  logic [7:0]  neg_port1_sel, pos_mv, neg_mv, p;
  logic [3:0]  neg_port2_sel, pos_channel_sel, pc, h;
  logic        neg_in_from_mux, neg_in_from_gnd, neg_in_from_dac, pos_in_from_mux, pos_in_from_dac;
  logic        dac_ref_from_neg, dac_ref_from_pos, pin_sync_out, pin_async_out, comp_irq;
  logic        reset_source, kill_trigger, cap_level, serr, eo, er, ef;
  int          num_errors, tests_run;
  integer      seed;
  localparam logic [11:0] C0 = comparator_pkg::CTRL0_OFFSET;
  localparam logic [11:0] MD = comparator_pkg::MODE_OFFSET;

  comparator_ctrl u_comparator_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .raw_result(raw_result), .capture_out(capture_out), .comp_power_on(comp_power_on),
    .hyst_pos_level(hyst_pos_level), .hyst_neg_level(hyst_neg_level), .hyst_pos_max(hyst_pos_max),
    .hyst_neg_max(hyst_neg_max), .neg_port1_sel(neg_port1_sel), .neg_port2_sel(neg_port2_sel),
    .neg_gnd_sel(neg_gnd_sel), .neg_vdd_sel(neg_vdd_sel), .pos_channel_sel(pos_channel_sel),
    .neg_in_from_mux(neg_in_from_mux), .neg_in_from_gnd(neg_in_from_gnd), .neg_in_from_dac(neg_in_from_dac),
    .pos_in_from_mux(pos_in_from_mux), .pos_in_from_dac(pos_in_from_dac), .dac_ref_from_neg(dac_ref_from_neg),
    .dac_ref_from_pos(dac_ref_from_pos), .dac_enable(dac_enable), .pin_sync_out(pin_sync_out),
    .pin_async_out(pin_async_out), .comp_irq(comp_irq), .reset_source(reset_source), .kill_trigger(kill_trigger));
  analog_front u_analog_front (.pos_mv(pos_mv), .neg_mv(neg_mv), .cap_level(cap_level),
    .raw_result(raw_result), .capture_out(capture_out));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [13:0] neg_exp(input logic [3:0] c);
    neg_exp = 14'h0;
    if (c < 4'h8) neg_exp[6 + c] = 1'b1;
    else if (c == 4'h8) neg_exp[1] = 1'b1;
    else if (c <= 4'hC) neg_exp[c - 7] = 1'b1;
    else if (c == 4'hF) neg_exp[0] = 1'b1;
  endfunction : neg_exp

  function automatic logic [7:0] arr_exp(input logic [1:0] m);
    case (m)
      2'h0:    arr_exp = 8'h90;
      2'h1:    arr_exp = 8'h50;
      2'h2:    arr_exp = 8'h35;
      default: arr_exp = 8'h8B;
    endcase
  endfunction : arr_exp

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) num_errors++;
    q = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic set_in(input logic [7:0] v, input logic c);
    @(posedge pclk);
    pos_mv <= v; cap_level <= c;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : set_in

  task automatic flags(input logic [2:0] e);
    apb(1'b0, C0, 32'h0);
    check("flags", {29'h0, e}, {29'h0, q[6:4]});
  endtask : flags

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    seed = 32'hC9DF; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; pos_mv = 8'h00; neg_mv = 8'h80; cap_level = 1'b1; num_errors = 0; tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check("reset value", 32'h0, q);
    end
    for (int c = 0; c < 16; c++) begin
      pc = 4'($random(seed));
      apb(1'b1, comparator_pkg::MUXSEL_OFFSET, {24'h0, 4'(c), pc});
      @(negedge pclk);
      check("neg_sel", 32'(neg_exp(4'(c))), 32'({neg_port1_sel, neg_port2_sel, neg_gnd_sel, neg_vdd_sel}));
      check("pos_sel", 32'(pc), 32'(pos_channel_sel));
    end
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, MD, 32'(m) << comparator_pkg::IN_SEL_LSB);
      @(negedge pclk);
      check("arrange", 32'(arr_exp(2'(m))), 32'({neg_in_from_mux, neg_in_from_gnd, neg_in_from_dac,
        pos_in_from_mux, pos_in_from_dac, dac_ref_from_neg, dac_ref_from_pos, dac_enable}));
    end
    repeat (4) begin
      h = 4'($random(seed));
      apb(1'b1, C0, {28'h0, h});
      apb(1'b0, C0, 32'h0);
      check("hyst", {28'h0, h}, q);
      check("hyst_lvl", {28'h0, h}, {28'h0, hyst_pos_level, hyst_neg_level});
      check("hyst_max", {30'h0, h[3:2] == 2'h3, h[1:0] == 2'h3}, {30'h0, hyst_pos_max, hyst_neg_max});
    end
    apb(1'b1, MD, 32'h0);
    apb(1'b1, C0, 32'h80);
    apb(1'b1, C0, 32'h80);
    set_in(8'hC0, 1'b1);
    check("pins", 32'h3, {30'h0, pin_sync_out, pin_async_out});
    check("triggers", 32'h3, {30'h0, reset_source, kill_trigger});
    flags(3'b110);
    set_in(8'h00, 1'b1);
    check("triggers", 32'h0, {30'h0, reset_source, kill_trigger});
    flags(3'b011);
    apb(1'b1, MD, 32'h1 << comparator_pkg::RISE_IE_BIT);
    @(negedge pclk);
    check("irq", 32'h1, {31'h0, comp_irq});
    apb(1'b1, C0, 32'h90);
    @(negedge pclk);
    check("irq", 32'h0, {31'h0, comp_irq});
    apb(1'b1, MD, 32'h1 << comparator_pkg::FALL_IE_BIT);
    @(negedge pclk);
    check("irq", 32'h1, {31'h0, comp_irq});
    apb(1'b1, C0, 32'h80);
    flags(3'b000);
    apb(1'b1, MD, 32'h1 << comparator_pkg::INVERT_BIT);
    repeat (2) @(posedge pclk);
    flags(3'b110);
    set_in(8'hC0, 1'b1);
    flags(3'b011);
    apb(1'b1, comparator_pkg::CTRL1_OFFSET, 32'h1);
    set_in(8'hC0, 1'b0);
    set_in(8'h00, 1'b0);
    check("held", 32'h0, {31'h0, pin_async_out});
    set_in(8'h00, 1'b1);
    check("released", 32'h1, {31'h0, pin_async_out});
    apb(1'b1, comparator_pkg::CTRL1_OFFSET, 32'h0);
    apb(1'b1, C0, 32'h00);
    @(negedge pclk);
    check("off", 32'h0, {30'h0, comp_power_on, pin_async_out});
    repeat (2) @(posedge pclk);
    flags(3'b001);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", 32'h1, {31'h0, serr});
    check("unmapped data", 32'h0, q);
    apb(1'b1, MD, 32'h0);
    apb(1'b1, C0, 32'h80);
    apb(1'b1, C0, 32'h80);
    eo = 1'b0; er = 1'b0; ef = 1'b0;
    repeat (12) begin
      p = 8'($random(seed));
      set_in(p, 1'b1);
      if ((p > 8'h80) != eo) begin
        er = er | ~eo;
        ef = ef | eo;
      end
      eo = p > 8'h80;
      flags({eo, er, ef});
    end
    report_and_stop();
  end
endmodule : comparator_input_output_control_tb
